// ===== src/crc16_checksum_unit_defs.svh
// Contract
// - a 16-bit crc with generator 0x1021 runs over every byte written.
// - seed select 0 gives seed 0x0000 and seed select 1 gives 0xFFFF.
// - a seed select change leaves the crc alone until the next clear.
// - writing 1 to engine clear resets the calculator; the bit reads 0.
// - an engine clear loads the seed selected by the same control write into the crc.
// - each byte written to the low data port folds into the last crc.
// - the data/result pair reads the crc of the last finished update.
// - input data and result share one location, no result register.
// - bit order 0 feeds each byte msb first and 1 feeds it lsb first.
// - control bits 7 to 3 read as zero and ignore writes.
// - a low data port write starts an update that ends by itself.
// - a read of the low data port returns the low byte of the crc.
// - the high result port ignores writes and reads the crc upper byte.
`ifndef CRC16_CHECKSUM_UNIT_DEFS_SVH
`define CRC16_CHECKSUM_UNIT_DEFS_SVH

// ****************************************************************
// register map
// ****************************************************************
`define CRC_ADDR_W 12
`define CRC_OFS_CONTROL 12'h000
`define CRC_OFS_DATA_LOW 12'h004
`define CRC_OFS_RESULT_HIGH 12'h008

// ****************************************************************
// control fields
// ****************************************************************
`define CRC_CTRL_CLEAR_BIT 0
`define CRC_CTRL_SEED_BIT 1
`define CRC_CTRL_ORDER_BIT 2
`define CRC_CTRL_RESET 8'h00

// ****************************************************************
// crc constants
// ****************************************************************
`define CRC_POLY 16'h1021
`define CRC_SEED_ZERO 16'h0000
`define CRC_SEED_ONES 16'hffff
`define CRC_RESULT_RESET 16'h0000
`define CRC_LAST_BIT 3'h7
`define CRC_BUF_DEPTH 2'h2

`endif

// ===== src/crc16_pkg.sv
`default_nettype none
package crc16_pkg;
    typedef logic [15:0] crc_word_t;
    typedef logic [7:0] data_byte_t;
    typedef enum logic [0:0] {ENG_IDLE, ENG_SHIFT} engine_state_t;
endpackage
`default_nettype wire

// ===== src/byte_stream_if.sv
`default_nettype none
interface byte_stream_if;
    logic in_valid;
    logic in_ready;
    crc16_pkg::data_byte_t in_data;
    logic out_valid;
    logic out_ready;
    crc16_pkg::data_byte_t out_data;

    modport core (
        output in_valid,
        output in_data,
        input in_ready,
        input out_valid,
        input out_data,
        output out_ready
    );

    modport fifo (
        input in_valid,
        input in_data,
        output in_ready,
        output out_valid,
        output out_data,
        input out_ready
    );
endinterface
`default_nettype wire

// ===== src/crc16_byte_buffer.sv
`include "crc16_checksum_unit_defs.svh"
`default_nettype none
module crc16_byte_buffer (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // byte stream
    byte_stream_if.fifo port
);

// ****************************************************************
// two-entry storage
// ****************************************************************
crc16_pkg::data_byte_t mem_r [2];
logic wr_ptr_r;
logic rd_ptr_r;
logic [1:0] count_r;
logic push;
logic pop;

assign port.in_ready = (count_r != `CRC_BUF_DEPTH);
assign port.out_valid = (count_r != 2'h0);
assign port.out_data = mem_r[rd_ptr_r];
assign push = port.in_valid & port.in_ready;
assign pop = port.out_valid & port.out_ready;

always_ff @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        mem_r[0] <= 8'h00;
        mem_r[1] <= 8'h00;
        wr_ptr_r <= 1'b0;
        rd_ptr_r <= 1'b0;
        count_r <= 2'h0;
    end
    else
    begin
        if (push)
        begin
            mem_r[wr_ptr_r] <= port.in_data;
            wr_ptr_r <= ~wr_ptr_r;
        end
        if (pop)
        begin
            rd_ptr_r <= ~rd_ptr_r;
        end
        if (push && !pop)
        begin
            count_r <= count_r + 2'h1;
        end
        else if (pop && !push)
        begin
            count_r <= count_r - 2'h1;
        end
    end
end

endmodule
`default_nettype wire

// ===== src/crc16_checksum_unit.sv
// The implementer's own choices: the placing of the registers and the APB slave port.
`include "crc16_checksum_unit_defs.svh"
`default_nettype none
module crc16_checksum_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`CRC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

// ****************************************************************
// functions
// ****************************************************************
function automatic crc16_pkg::crc_word_t crc_step(
    input crc16_pkg::crc_word_t crc,
    input logic din
);
    crc16_pkg::crc_word_t res;
    res = {crc[14:0], 1'b0};
    if (crc[15] ^ din)
    begin
        res = res ^ `CRC_POLY;
    end
    return res;
endfunction

function automatic logic pick_bit(
    input crc16_pkg::data_byte_t data,
    input logic [2:0] idx,
    input logic lsb_first
);
    logic [2:0] pos;
    pos = lsb_first ? idx : (`CRC_LAST_BIT - idx);
    return data[pos];
endfunction

// ****************************************************************
// decode functions
// ****************************************************************
function automatic logic addr_hit(
    input logic [`CRC_ADDR_W-1:0] addr,
    input logic [`CRC_ADDR_W-1:0] ofs
);
    return (addr == ofs);
endfunction

function automatic logic [31:0] byte_word(
    input crc16_pkg::data_byte_t value
);
    return {24'h00_0000, value};
endfunction

function automatic crc16_pkg::crc_word_t seed_of(
    input logic ones
);
    return ones ? `CRC_SEED_ONES : `CRC_SEED_ZERO;
endfunction

// ****************************************************************
// declarations
// ****************************************************************
byte_stream_if bus_if ();

crc16_pkg::engine_state_t state_r;
crc16_pkg::engine_state_t state_nxt;
crc16_pkg::crc_word_t crc_r;
crc16_pkg::crc_word_t crc_nxt;
crc16_pkg::data_byte_t byte_r;
crc16_pkg::data_byte_t byte_nxt;
logic [2:0] count_r;
logic [2:0] count_nxt;
logic bit_order_r;
logic seed_select_r;
logic pready_r;
logic pslverr_r;
logic [31:0] prdata_r;

logic access;
logic sel_ctrl;
logic sel_low;
logic sel_high;
logic mapped;
logic engine_idle;
logic can_answer;
logic pready_nxt;
logic commit;
logic wr_en;
logic wr_ctrl;
logic clear_req;
logic cur_bit;
logic [31:0] rd_value;
logic [7:0] ctrl_value;
crc16_pkg::crc_word_t seed;
logic bit_order_nxt;
logic seed_select_nxt;
logic pslverr_nxt;
logic [31:0] prdata_nxt;
logic [31:0] rd_ctrl_word;
logic [31:0] rd_low_word;
logic [31:0] rd_high_word;
logic data_write;
logic shift_idle;

localparam logic [7:0] ctrl_reset_value = `CRC_CTRL_RESET;

// ****************************************************************
// byte buffer
// ****************************************************************
crc16_byte_buffer u_buffer (
    .clk(clk),
    .rst(rst),
    .port(bus_if)
);

// ****************************************************************
// apb decode
// ****************************************************************
assign access = psel & penable;
assign sel_ctrl = addr_hit(paddr, `CRC_OFS_CONTROL);
assign sel_low = addr_hit(paddr, `CRC_OFS_DATA_LOW);
assign sel_high = addr_hit(paddr, `CRC_OFS_RESULT_HIGH);
assign mapped = sel_ctrl | sel_low | sel_high;
assign data_write = pwrite & sel_low;

// ****************************************************************
// answer timing
// ****************************************************************
assign shift_idle = (state_r == crc16_pkg::ENG_IDLE);
assign engine_idle = shift_idle & ~bus_if.out_valid;
assign can_answer = ~mapped ? 1'b1 :
                    data_write ? bus_if.in_ready :
                    engine_idle;
assign pready_nxt = access & ~pready_r & can_answer;
assign commit = access & pready_r;
assign wr_en = commit & pwrite & pstrb[0];
assign wr_ctrl = wr_en & sel_ctrl;
assign clear_req = wr_ctrl & pwdata[`CRC_CTRL_CLEAR_BIT];

// ****************************************************************
// read data
// ****************************************************************
assign ctrl_value = {5'h00, bit_order_r, seed_select_r, 1'b0};
assign rd_ctrl_word = byte_word(ctrl_value);
assign rd_low_word = byte_word(crc_r[7:0]);
assign rd_high_word = byte_word(crc_r[15:8]);
assign rd_value = sel_ctrl ? rd_ctrl_word :
                  sel_low ? rd_low_word :
                  sel_high ? rd_high_word :
                  32'h0000_0000;

// ****************************************************************
// bus response registers
// ****************************************************************
assign pslverr_nxt = pready_nxt & ~mapped;
assign prdata_nxt = (pready_nxt & ~pwrite) ? rd_value : 32'h0000_0000;

always_ff @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        pready_r <= 1'b0;
    end
    else
    begin
        pready_r <= pready_nxt;
    end
end

// ****************************************************************
// error flag register
// ****************************************************************
always_ff @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        pslverr_r <= 1'b0;
    end
    else
    begin
        pslverr_r <= pslverr_nxt;
    end
end

// ****************************************************************
// read data register
// ****************************************************************
always_ff @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        prdata_r <= 32'h0000_0000;
    end
    else
    begin
        prdata_r <= prdata_nxt;
    end
end

assign pready = pready_r;
assign pslverr = pslverr_r;
assign prdata = prdata_r;

// ****************************************************************
// control register
// ****************************************************************
assign bit_order_nxt = wr_ctrl ? pwdata[`CRC_CTRL_ORDER_BIT] : bit_order_r;
assign seed_select_nxt = wr_ctrl ? pwdata[`CRC_CTRL_SEED_BIT] :
                         seed_select_r;

always_ff @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        bit_order_r <= ctrl_reset_value[`CRC_CTRL_ORDER_BIT];
    end
    else
    begin
        bit_order_r <= bit_order_nxt;
    end
end

always_ff @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        seed_select_r <= ctrl_reset_value[`CRC_CTRL_SEED_BIT];
    end
    else
    begin
        seed_select_r <= seed_select_nxt;
    end
end

// ****************************************************************
// data push
// ****************************************************************
assign bus_if.in_valid = wr_en & sel_low;
assign bus_if.in_data = pwdata[7:0];

// ****************************************************************
// buffer drain
// ****************************************************************
assign bus_if.out_ready = shift_idle;

// ****************************************************************
// crc engine
// ****************************************************************
assign seed = seed_of(seed_select_nxt);
assign cur_bit = pick_bit(byte_r, count_r, bit_order_r);

always_comb
begin
    state_nxt = state_r;
    crc_nxt = crc_r;
    byte_nxt = byte_r;
    count_nxt = count_r;
    unique case (state_r)
        crc16_pkg::ENG_IDLE:
        begin
            if (bus_if.out_valid)
            begin
                byte_nxt = bus_if.out_data;
                count_nxt = 3'h0;
                state_nxt = crc16_pkg::ENG_SHIFT;
            end
        end
        crc16_pkg::ENG_SHIFT:
        begin
            crc_nxt = crc_step(crc_r, cur_bit);
            count_nxt = count_r + 3'h1;
            if (count_r == `CRC_LAST_BIT)
            begin
                state_nxt = crc16_pkg::ENG_IDLE;
            end
        end
    endcase
    if (clear_req)
    begin
        crc_nxt = seed;
    end
end

// ****************************************************************
// engine state registers
// ****************************************************************
always_ff @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        state_r <= crc16_pkg::ENG_IDLE;
    end
    else
    begin
        state_r <= state_nxt;
    end
end

always_ff @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        byte_r <= 8'h00;
    end
    else
    begin
        byte_r <= byte_nxt;
    end
end

always_ff @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        count_r <= 3'h0;
    end
    else
    begin
        count_r <= count_nxt;
    end
end

// ****************************************************************
// accumulator
// ****************************************************************
// one accumulator serves as both input target and result
always_ff @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        crc_r <= `CRC_RESULT_RESET;
    end
    else
    begin
        crc_r <= crc_nxt;
    end
end

endmodule
`default_nettype wire

// ===== verif/crc16_checksum_unit_monitor.sv
`include "crc16_checksum_unit_defs.svh"
`default_nettype none
module crc16_checksum_unit_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`CRC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic fresh_r;
    logic seed_r;
    wire wr_go = psel && penable && pready && pwrite && pstrb[0];
    wire rd_done = pready && !pwrite;
    wire at_ct = paddr == `CRC_OFS_CONTROL;
    wire at_lo = paddr == `CRC_OFS_DATA_LOW;
    wire at_hi = paddr == `CRC_OFS_RESULT_HIGH;
    wire mapped = at_ct || at_lo || at_hi;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ****************************************************************
    // seed tracking: set by a clear, dropped by a byte
    // ****************************************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fresh_r <= 1'b1;
            seed_r <= 1'b0;
        end
        else if (wr_go && at_ct && pwdata[0])
        begin
            fresh_r <= 1'b1;
            seed_r <= pwdata[1];
        end
        else if (wr_go && at_lo)
            fresh_r <= 1'b0;
    end
    // ****************************************************************
    // properties
    // ****************************************************************
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    property p_answer; s_setup ##1 s_access |-> ##[1:60] pready; endproperty
    property p_one; pready |=> !pready; endproperty
    property p_bus; pready |-> psel && penable; endproperty
    property p_err; pready || pslverr |-> pready && pslverr == !mapped;
    endproperty
    property p_ctl; rd_done && at_ct |-> prdata[31:3] == 0 && !prdata[0];
    endproperty
    property p_lo; rd_done && at_lo |-> prdata[31:8] == 0; endproperty
    property p_hi; rd_done && at_hi |-> prdata[31:8] == 0; endproperty
    property p_seed; fresh_r && rd_done && (at_lo || at_hi)
        |-> prdata[7:0] == {8{seed_r}}; endproperty
    property p_idle; !pready |-> prdata == 0; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    a_one: assert property (p_one) else $error("pready too long");
    a_bus: assert property (p_bus) else $error("stray pready");
    a_err: assert property (p_err) else $error("bad pslverr");
    a_ctl: assert property (p_ctl) else $error("bad control");
    a_lo: assert property (p_lo) else $error("bad low read");
    a_hi: assert property (p_hi) else $error("bad high read");
    a_seed: assert property (p_seed) else $error("bad seed");
    a_idle: assert property (p_idle) else $error("stray prdata");
endmodule
bind crc16_checksum_unit crc16_checksum_unit_monitor mon_u (.clk(clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ===== verif/test_crc16_checksum_unit.sv
`include "crc16_checksum_unit_defs.svh"
`default_nettype none
module test_crc16_checksum_unit;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] ct = `CRC_OFS_CONTROL;
    localparam logic [11:0] lo = `CRC_OFS_DATA_LOW;
    localparam logic [11:0] hi = `CRC_OFS_RESULT_HIGH;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = '0;
    logic [31:0] prdata;
    logic pready, pslverr, seed_m = 0, lsb_m = 0;
    logic [32:0] notes[$];
    logic [15:0] crc_m = '0;
    int err_count = 0, n_tests = 0;
    always #20 clk = ~clk;
    crc16_checksum_unit dut_u (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b,
        logic l);
        logic fb;
        for (int k = 0; k < 8; k++)
        begin
            fb = c[15] ^ (l ? b[k] : b[7-k]);
            c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
        end
        return c;
    endfunction
    task automatic cmp_resp(input logic [32:0] exp, input logic [32:0] got);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH pslverr_prdata exp %h got %h", exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one apb transfer; the expected answer is queued first
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = '0;
        if (!w && a == ct)
            r = {29'd0, lsb_m, seed_m, 1'b0};
        if (!w && a == lo)
            r = {24'd0, crc_m[7:0]};
        if (!w && a == hi)
            r = {24'd0, crc_m[15:8]};
        notes.push_back({!(a == ct || a == lo || a == hi), r});
        if (w && s[0] && a == ct)
        begin
            lsb_m = d[2];
            seed_m = d[1];
            if (d[0])
                crc_m = {16{d[1]}};
        end
        if (w && s[0] && a == lo)
            crc_m = crc_step(crc_m, d[7:0], lsb_m);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    // response watcher
    always @(posedge clk)
    begin
        if (pready === 1'b1)
        begin
            if (notes.size() == 0)
                cmp_resp('x, {pslverr, prdata});
            else
                cmp_resp(notes.pop_front(), {pslverr, prdata});
        end
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish;
    end
    initial
    begin
        int i;
        int j;
        void'($urandom(32'h8ce9));
        repeat (10) @(posedge clk);
        rst <= 0;
        xfer(0, ct, 0, 4'hf);
        xfer(0, hi, 0, 4'hf);
        xfer(1, ct, 32'hffff_fffb, 4'hf);
        xfer(0, ct, 0, 4'hf);
        for (i = 0; i < 9; i++)
            xfer(1, lo, 32'h0000_0031 + 32'(i), 4'hf);
        xfer(0, lo, 0, 4'hf);
        xfer(0, hi, 0, 4'hf);
        xfer(1, hi, 32'h0000_00a5, 4'hf);
        xfer(1, lo, 32'h0000_0077, 4'h0);
        xfer(1, ct, 32'h0000_0000, 4'hf);
        xfer(0, lo, 0, 4'hf);
        xfer(1, ct, 32'h0000_0001, 4'hf);
        xfer(0, hi, 0, 4'hf);
        xfer(0, 12'h00c, 0, 4'hf);
        xfer(1, 12'h404, $urandom, 4'hf);
        for (i = 0; i < 4; i++)
        begin
            xfer(1, ct, {29'd0, i[1:0], 1'b1}, 4'hf);
            for (j = 0; j < 5; j++)
                xfer(1, lo, $urandom, 4'hf);
            xfer(0, lo, 0, 4'hf);
            xfer(0, hi, 0, 4'hf);
        end
        tally_and_finish;
    end
endmodule
`default_nettype wire
